// ===== design/adc_i2c_slave_port.sv
/*
 Slave port of a 24-bit converter on a two-wire bus, with open-drain ready pin.
 Assumes link_clk oversamples the bus lines well above 1 Mbps and clk is the
 modulator clock that times the idle timeout and the ready pin.
*/
// Contract
// - Slave only, serial clock never driven
// - Address is 100, high code, low code
// - Straps re-sampled every transaction at start
// - Lines only pulled low or released
// - Data changes only while clock low
// - Falling data with clock high starts
// - Seven address bits then direction bit
// - Ninth clock: acknowledge match, else release
// - Bytes MSB first, unlimited count
// - Receiver acknowledges every byte
// - Rising data with clock high stops
// - General call write; 06h resets device
// - Idle 14000 modulator periods resets interface
// - Ready low on result, high when latched
// - Unread continuous result releases ready briefly
// - Speeds up to 1 Mbps supported
// - Results are 24-bit two's complement
// - Command takes effect on eighth fall
`timescale 1ns/1ps
`include "adc_i2c_params.svh"

module adc_i2c_slave_port #(
    parameter int unsigned TIMEOUT_CYCLES = `TIMEOUT_MOD_PERIODS
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        link_clk,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    input  wire logic        addr_select_pin_lo,
    input  wire logic        addr_select_pin_hi,
    output logic             conversion_done_n_out,
    output logic             conversion_done_n_oe,
    input  wire logic        result_valid,
    input  wire logic [23:0] result_data,
    input  wire logic        result_load,
    input  wire logic        cont_mode,
    output logic             cmd_valid,
    output logic [7:0]       cmd_byte,
    output logic             device_reset
);
    import adc_i2c_pkg::*;

    localparam int unsigned REL_CYCLES = (`RELEASE_CYCLES < 1) ? 1 : `RELEASE_CYCLES;

    function automatic logic [7:0] tx_byte(input logic [23:0] w, input logic [1:0] idx);
        tx_byte = (idx == 2'h3) ? 8'h00 : w[5'(23 - 8 * idx) -: 8];
    endfunction

    // -------------------------------------------------------------------------
    // Link domain: synchronisers
    // -------------------------------------------------------------------------
    logic [3:0] pin_s1_r, pin_s2_r;
    logic       scl_p_r, sda_p_r;
    logic [2:0] lrst_r;
    logic [1:0] tout_s_r, tx_s_r;
    logic       tout_p_r, tx_p_r;
    logic       link_rst;

    always_ff @(posedge link_clk) begin
        pin_s1_r <= {addr_select_pin_hi, addr_select_pin_lo, sda_in, scl_in};
        pin_s2_r <= pin_s1_r;
        {sda_p_r, scl_p_r} <= pin_s2_r[1:0];
        lrst_r   <= {lrst_r[1:0], rst};
    end
    assign link_rst = lrst_r[1] | lrst_r[2];

    logic scl, sda, scl_rise, scl_fall, start_ev, stop_ev;
    assign scl      = pin_s2_r[0];
    assign sda      = pin_s2_r[1];
    assign scl_rise = scl & ~scl_p_r;
    assign scl_fall = ~scl & scl_p_r;
    assign start_ev = scl & scl_p_r & sda_p_r & ~sda;
    assign stop_ev  = scl & scl_p_r & ~sda_p_r & sda;

    // -------------------------------------------------------------------------
    // Link domain: strap decode
    // -------------------------------------------------------------------------
    logic [1:0]  smp_high_r, smp_dlow_r, smp_clow_r;
    strap_code_t code_lo, code_hi;
    logic [6:0]  dev_addr;

    strap_code_decoder u_dec_lo (
        .smp_both_high (smp_high_r[0]),
        .smp_data_low  (smp_dlow_r[0]),
        .smp_clock_low (smp_clow_r[0]),
        .code          (code_lo)
    );
    strap_code_decoder u_dec_hi (
        .smp_both_high (smp_high_r[1]),
        .smp_data_low  (smp_dlow_r[1]),
        .smp_clock_low (smp_clow_r[1]),
        .code          (code_hi)
    );
    assign dev_addr = {`ADDR_PREFIX, code_hi, code_lo};

    // -------------------------------------------------------------------------
    // Link domain: transfer state machine
    // -------------------------------------------------------------------------
    link_state_t state_r, state_nxt;
    logic [3:0]  cnt_r, cnt_nxt;
    logic [7:0]  sh_r, sh_nxt;
    logic        rw_r, rw_nxt, gc_r, gc_nxt, nack_r, nack_nxt;
    logic        sda_low_r, sda_low_nxt;
    logic [1:0]  bidx_r, bidx_nxt;
    logic [23:0] txw_r, txw_nxt;
    logic [1:0]  smp_high_nxt, smp_dlow_nxt, smp_clow_nxt;
    logic [7:0]  cmd_l_r, cmd_l_nxt;
    logic        cmd_tog_r, cmd_tog_nxt, gcr_tog_r, gcr_tog_nxt, act_tog_r, act_tog_nxt;
    logic        tout_hit, tx_new, tout_tog_r, tx_tog_r;
    logic [23:0] tx_word_r;

    assign tout_hit = tout_s_r[1] ^ tout_p_r;
    assign tx_new   = tx_s_r[1] ^ tx_p_r;

    always_comb begin
        state_nxt    = state_r;
        {cnt_nxt, sh_nxt, rw_nxt, gc_nxt, nack_nxt, sda_low_nxt, bidx_nxt} =
            {cnt_r, sh_r, rw_r, gc_r, nack_r, sda_low_r, bidx_r};
        txw_nxt      = tx_new ? tx_word_r : txw_r;
        {smp_high_nxt, smp_dlow_nxt, smp_clow_nxt, cmd_l_nxt, cmd_tog_nxt, gcr_tog_nxt} =
            {smp_high_r, smp_dlow_r, smp_clow_r, cmd_l_r, cmd_tog_r, gcr_tog_r};
        act_tog_nxt  = act_tog_r ^ ((scl_rise | scl_fall) & (state_r != st_idle));
        if (scl & sda) begin
            smp_high_nxt = pin_s2_r[3:2];
        end
        if (scl_rise && state_r != st_idle) begin
            cnt_nxt = cnt_r + 4'h1;
        end
        unique case (state_r)
            st_idle, st_ignore: begin
            end
            st_addr: begin
                if (scl_rise) begin
                    sh_nxt = {sh_r[6:0], sda};
                end
                if (scl_fall && cnt_r == 4'h0) begin
                    smp_clow_nxt = pin_s2_r[3:2];
                end
                if (scl_fall && cnt_r == `BITS_PER_BYTE) begin
                    rw_nxt  = sh_r[0];
                    gc_nxt  = (sh_r[7:1] == `GEN_CALL_ADDR) && !sh_r[0];
                    cnt_nxt = 4'h0;
                    if (sh_r[7:1] == dev_addr || gc_nxt) begin
                        sda_low_nxt = 1'b1;
                        state_nxt   = st_addr_ack;
                    end else begin
                        state_nxt = st_ignore;
                    end
                end
            end
            st_addr_ack: begin
                if (scl_fall) begin
                    cnt_nxt = 4'h0;
                    if (rw_r) begin
                        sh_nxt      = tx_byte(txw_r, 2'h0);
                        bidx_nxt    = 2'h1;
                        sda_low_nxt = ~sh_nxt[7];
                        state_nxt   = st_rd_byte;
                    end else begin
                        sda_low_nxt = 1'b0;
                        state_nxt   = st_wr_byte;
                    end
                end
            end
            st_wr_byte: begin
                if (scl_rise) begin
                    sh_nxt = {sh_r[6:0], sda};
                end
                if (scl_fall && cnt_r == `BITS_PER_BYTE) begin
                    cmd_l_nxt   = sh_r;
                    cmd_tog_nxt = ~cmd_tog_r;
                    if (gc_r && sh_r == `GEN_CALL_RESET) begin
                        gcr_tog_nxt = ~gcr_tog_r;
                    end
                    gc_nxt      = 1'b0;
                    cnt_nxt     = 4'h0;
                    sda_low_nxt = 1'b1;
                    state_nxt   = st_wr_ack;
                end
            end
            st_wr_ack: begin
                if (scl_fall) begin
                    sda_low_nxt = 1'b0;
                    cnt_nxt     = 4'h0;
                    state_nxt   = st_wr_byte;
                end
            end
            st_rd_byte: begin
                if (scl_fall) begin
                    if (cnt_r == `BITS_PER_BYTE) begin
                        sda_low_nxt = 1'b0;
                        cnt_nxt     = 4'h0;
                        state_nxt   = st_rd_ack;
                    end else begin
                        sh_nxt      = {sh_r[6:0], 1'b0};
                        sda_low_nxt = ~sh_r[6];
                    end
                end
            end
            st_rd_ack: begin
                if (scl_rise) begin
                    nack_nxt = sda;
                end
                if (scl_fall) begin
                    cnt_nxt = 4'h0;
                    if (nack_r) begin
                        state_nxt = st_ignore;
                    end else begin
                        sh_nxt      = tx_byte(txw_r, bidx_r);
                        bidx_nxt    = (bidx_r > `RESULT_LAST_BYTE) ? bidx_r : bidx_r + 2'h1;
                        sda_low_nxt = ~sh_nxt[7];
                        state_nxt   = st_rd_byte;
                    end
                end
            end
        endcase
        if (start_ev) begin
            state_nxt    = st_addr;
            cnt_nxt      = 4'h0;
            sda_low_nxt  = 1'b0;
            smp_dlow_nxt = pin_s2_r[3:2];
        end
        if (stop_ev || tout_hit) begin
            state_nxt   = st_idle;
            sda_low_nxt = 1'b0;
            gc_nxt      = 1'b0;
        end
    end

    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            state_r <= st_idle;
            {cnt_r, sh_r, rw_r, gc_r, nack_r, sda_low_r, bidx_r, txw_r} <= '0;
            {smp_high_r, smp_dlow_r, smp_clow_r, cmd_l_r} <= '0;
            {cmd_tog_r, gcr_tog_r, act_tog_r, tout_p_r, tout_s_r, tx_p_r, tx_s_r} <= '0;
        end else begin
            state_r <= state_nxt;
            {cnt_r, sh_r, rw_r, gc_r, nack_r, sda_low_r, bidx_r, txw_r} <=
                {cnt_nxt, sh_nxt, rw_nxt, gc_nxt, nack_nxt, sda_low_nxt, bidx_nxt, txw_nxt};
            {smp_high_r, smp_dlow_r, smp_clow_r, cmd_l_r} <=
                {smp_high_nxt, smp_dlow_nxt, smp_clow_nxt, cmd_l_nxt};
            {cmd_tog_r, gcr_tog_r, act_tog_r} <= {cmd_tog_nxt, gcr_tog_nxt, act_tog_nxt};
            {tout_p_r, tout_s_r} <= {tout_s_r, tout_tog_r};
            {tx_p_r, tx_s_r} <= {tx_s_r, tx_tog_r};
        end
    end

    // The clock line has no output at all; data is only ever pulled low.
    assign sda_out = 1'b0;
    assign sda_oe  = sda_low_r;

    // -------------------------------------------------------------------------
    // System domain: crossings from the link
    // -------------------------------------------------------------------------
    logic [2:0] cmd_s_r, gcr_s_r, act_s_r, busy_s_r;
    logic       cmd_ev, gcr_ev, act_ev, busy;

    // Command bytes stay put for a whole byte time, far longer than the
    // toggle takes to cross, so the byte is read directly on the toggle edge.
    always_ff @(posedge clk) begin
        cmd_s_r  <= {cmd_s_r[1:0], cmd_tog_r};
        gcr_s_r  <= {gcr_s_r[1:0], gcr_tog_r};
        act_s_r  <= {act_s_r[1:0], act_tog_r};
        busy_s_r <= {busy_s_r[1:0], state_r != st_idle};
    end
    assign cmd_ev = cmd_s_r[2] ^ cmd_s_r[1];
    assign gcr_ev = gcr_s_r[2] ^ gcr_s_r[1];
    assign act_ev = act_s_r[2] ^ act_s_r[1];
    assign busy   = busy_s_r[1];

    // -------------------------------------------------------------------------
    // System domain: commands, timeout, results, ready pin
    // -------------------------------------------------------------------------
    logic        cmd_valid_nxt, dev_rst_nxt, tout_tog_nxt;
    logic [7:0]  cmd_byte_nxt;
    logic [13:0] tmo_r, tmo_nxt;
    logic [23:0] latest_r, latest_nxt, tx_word_nxt;
    logic        tx_tog_nxt, conversion_done_n_low_r, conversion_done_n_low_nxt;
    logic [3:0]  rel_r, rel_nxt;

    always_comb begin
        cmd_valid_nxt = cmd_ev;
        cmd_byte_nxt  = cmd_ev ? cmd_l_r : cmd_byte;
        dev_rst_nxt   = gcr_ev;
        tout_tog_nxt  = tout_tog_r;
        tmo_nxt       = tmo_r + 14'h1;
        if (!busy || act_ev) begin
            tmo_nxt = 14'h0;
        end else if (tmo_r >= 14'(TIMEOUT_CYCLES - 1)) begin
            tmo_nxt      = 14'h0;
            tout_tog_nxt = ~tout_tog_r;
        end
        latest_nxt   = result_valid ? result_data : latest_r;
        {tx_word_nxt, tx_tog_nxt, conversion_done_n_low_nxt} = {tx_word_r, tx_tog_r, conversion_done_n_low_r};
        rel_nxt      = (rel_r != 4'h0) ? rel_r - 4'h1 : rel_r;
        if (rel_r == 4'h1) begin
            conversion_done_n_low_nxt = 1'b1;
        end
        if (result_valid) begin
            if (conversion_done_n_low_r && cont_mode) begin
                conversion_done_n_low_nxt = 1'b0;
                rel_nxt      = 4'(REL_CYCLES);
            end else if (rel_r == 4'h0) begin
                conversion_done_n_low_nxt = 1'b1;
            end
        end
        if (result_load) begin
            tx_word_nxt  = result_valid ? result_data : latest_r;
            tx_tog_nxt   = ~tx_tog_r;
            conversion_done_n_low_nxt = 1'b0;
            rel_nxt      = 4'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            {cmd_valid, cmd_byte, device_reset, tout_tog_r, tmo_r} <= '0;
            {latest_r, tx_word_r, tx_tog_r, conversion_done_n_low_r, rel_r} <= '0;
        end else begin
            {cmd_valid, cmd_byte, device_reset, tout_tog_r, tmo_r} <=
                {cmd_valid_nxt, cmd_byte_nxt, dev_rst_nxt, tout_tog_nxt, tmo_nxt};
            {latest_r, tx_word_r, tx_tog_r, conversion_done_n_low_r, rel_r} <=
                {latest_nxt, tx_word_nxt, tx_tog_nxt, conversion_done_n_low_nxt, rel_nxt};
        end
    end

    // Open drain: the pin is pulled low while a fresh result waits.
    assign conversion_done_n_out = 1'b0;
    assign conversion_done_n_oe  = conversion_done_n_low_r;

endmodule

// ===== common/adc_i2c_params.svh
/*
 Constants of the converter's two-wire slave port: address layout, general-call
 values, bit counts and timing counts. Assumes the system clock is the modulator clock.
*/
`ifndef ADC_I2C_PARAMS_SVH
`define ADC_I2C_PARAMS_SVH

// -----------------------------------------------------------------------------
// Addressing
// -----------------------------------------------------------------------------
`define ADDR_PREFIX        3'b100
`define GEN_CALL_ADDR      7'h00
`define GEN_CALL_RESET     8'h06
`define STRAP_GROUND       2'b00
`define STRAP_SUPPLY       2'b01
`define STRAP_DATA_LINE    2'b10
`define STRAP_CLOCK_LINE   2'b11

// -----------------------------------------------------------------------------
// Framing
// -----------------------------------------------------------------------------
`define BITS_PER_BYTE      4'h8
`define RESULT_BITS        24
`define RESULT_LAST_BYTE   2'h2

// -----------------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------------
`define CLK_PERIOD_NS      100
`define TIMEOUT_MOD_PERIODS 14000
`define RELEASE_WIDTH_NS   1000
`define RELEASE_CYCLES     ((`RELEASE_WIDTH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== common/adc_i2c_pkg.sv
/*
 Types shared by the two-wire slave port and its strap decoder.
 Assumes the constants header is included by the design files that need numbers.
*/
package adc_i2c_pkg;

    typedef logic [1:0] strap_code_t;

    typedef enum logic [2:0] {
        st_idle,
        st_addr,
        st_addr_ack,
        st_wr_byte,
        st_wr_ack,
        st_rd_byte,
        st_rd_ack,
        st_ignore
    } link_state_t;

endpackage

// ===== design/strap_code_decoder.sv
/*
 Turns three samples of one four-state address strap into its two-bit code.
 Assumes the samples were taken with both lines high, just after the start
 condition, and at the first clock fall of the address byte.
*/
`timescale 1ns/1ps
`include "adc_i2c_params.svh"

module strap_code_decoder (
    input  wire logic                    smp_both_high,
    input  wire logic                    smp_data_low,
    input  wire logic                    smp_clock_low,
    output adc_i2c_pkg::strap_code_t     code
);
    import adc_i2c_pkg::*;

    // -------------------------------------------------------------------------
    // Decode
    // -------------------------------------------------------------------------
    // A strap tied to a line follows it: low with data low, low with clock low.
    always_comb begin
        if (!smp_both_high) begin
            code = `STRAP_GROUND;
        end else if (!smp_data_low) begin
            code = `STRAP_DATA_LINE;
        end else if (!smp_clock_low) begin
            code = `STRAP_CLOCK_LINE;
        end else begin
            code = `STRAP_SUPPLY;
        end
    end

endmodule

// ===== tb/adc_i2c_slave_port_checker.sv
/*
 Port checks of the two-wire slave port.
 Assumes a bind to the port and rst high as both clocks start.
*/
`timescale 1ns/1ps
module adc_i2c_slave_port_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic link_clk,
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic conversion_done_n_out,
    input wire logic conversion_done_n_oe,
    input wire logic result_valid,
    input wire logic result_load,
    input wire logic cont_mode,
    input wire logic cmd_valid,
    input wire logic device_reset
);
    // -------------------------------------------------------------------------
    // Properties
    // -------------------------------------------------------------------------
    AST_OPEN_DRAIN:
    assert property (@(posedge clk) disable iff (rst) !sda_out && !conversion_done_n_out)
        else $error("open-drain pin driven high");
    AST_SDA_MOVES_SCL_LOW:
    assert property (@(posedge link_clk) disable iff (rst)
        $changed(sda_oe) |-> !scl_in && !$past(scl_in)) else $error("data moved, clock high");
    AST_READY_SET:
    assert property (@(posedge clk) disable iff (rst)
        result_valid && !result_load && !conversion_done_n_oe |=> conversion_done_n_oe)
        else $error("ready not raised on new result");
    AST_READY_CLEAR:
    assert property (@(posedge clk) disable iff (rst) result_load |=> !conversion_done_n_oe)
        else $error("ready not cleared on latch");
    AST_READY_HOLD:
    assert property (@(posedge clk) disable iff (rst)
        conversion_done_n_oe && !result_load && !result_valid |=> conversion_done_n_oe)
        else $error("ready dropped without latch");
    AST_RELEASE_LOW:
    assert property (@(posedge clk) disable iff (rst)
        cont_mode && result_valid && !result_load && conversion_done_n_oe
        |=> (!conversion_done_n_oe) [*8]) else $error("release pulse too short");
    AST_RELEASE_END:
    assert property (@(posedge clk) disable iff (rst)
        cont_mode && result_valid && !result_load && conversion_done_n_oe
        |-> ##11 conversion_done_n_oe) else $error("release pulse did not end");
    AST_CMD_ONE_CYCLE:
    assert property (@(posedge clk) disable iff (rst) cmd_valid |=> !cmd_valid)
        else $error("command strobe too long");
    AST_RESET_ONE_CYCLE:
    assert property (@(posedge clk) disable iff (rst) device_reset |=> !device_reset)
        else $error("reset strobe too long");
    COV_CMD: cover property (@(posedge clk) disable iff (rst) cmd_valid);
    COV_RESET: cover property (@(posedge clk) disable iff (rst) device_reset);
    COV_ACK: cover property (@(posedge link_clk) disable iff (rst) $rose(sda_oe));
    COV_RELEASE: cover property (@(posedge clk) disable iff (rst)
        cont_mode && result_valid && conversion_done_n_oe);
endmodule

bind adc_i2c_slave_port adc_i2c_slave_port_checker chk (
    .clk(clk), .rst(rst), .link_clk(link_clk), .scl_in(scl_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .conversion_done_n_out(conversion_done_n_out),
    .conversion_done_n_oe(conversion_done_n_oe), .result_valid(result_valid),
    .result_load(result_load), .cont_mode(cont_mode), .cmd_valid(cmd_valid),
    .device_reset(device_reset));

// ===== tb/i2c_host_model.sv
/*
 Two-wire bus master that only pulls lines low.
 Assumes pull-ups on both lines in the bench.
*/
`timescale 1ns/1ps
module i2c_host_model (
    output logic     scl_oe,
    output logic     sda_oe,
    input wire logic sda
);
    // -------------------------------------------------------------------------
    // Bus cycles
    // -------------------------------------------------------------------------
    localparam int HALF = 500;
    // Lines start released, so the clock stands high between frames.
    initial begin
        scl_oe = 1'b0;
        sda_oe = 1'b0;
    end
    // Data moves an eighth of a period (HALF / 4) after the fall, so it never races the clock edge.
    task automatic start_cond();
        #(HALF / 4) sda_oe = 1'b0;
        #(HALF) scl_oe = 1'b0;
        #(HALF) sda_oe = 1'b1;
        #(HALF) scl_oe = 1'b1;
    endtask
    task automatic stop_cond();
        #(HALF / 4) sda_oe = 1'b1;
        #(HALF) scl_oe = 1'b0;
        #(HALF) sda_oe = 1'b0;
        #(HALF);
    endtask
    task automatic clock_bit(input logic b, output logic s);
        #(HALF / 4) sda_oe = ~b;
        #(HALF * 3 / 4) scl_oe = 1'b0;
        #(HALF / 2) s = sda;
        #(HALF / 2) scl_oe = 1'b1;
    endtask
    task automatic send_byte(input logic [7:0] b, input bit hold, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clock_bit(b[i], s);
        ack = 1'b1;
        if (!hold) clock_bit(1'b1, ack);
    endtask
    task automatic recv_byte(input logic ack_n, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) clock_bit(1'b1, b[i]);
        clock_bit(ack_n, s);
    endtask
endmodule

// ===== tb/testbench.sv
/*
 Self-checking bench for the two-wire slave port.
 Assumes the design, checker and master model are compiled first.
*/
`timescale 1ns/1ps
`include "adc_i2c_params.svh"
module testbench;
    // -------------------------------------------------------------------------
    // Harness
    // -------------------------------------------------------------------------
    localparam int unsigned TMO = 200;
    logic        clk, rst, link_clk, result_valid, result_load, cont_mode;
    logic [23:0] result_data;
    logic [1:0]  sel_hi, sel_lo;
    logic        h_scl_oe, h_sda_oe, sda_out, sda_oe, done_out, done_oe;
    logic        cmd_valid, device_reset;
    logic [7:0]  cmd_byte;
    wire logic   scl_w, sda_w, pin_hi, pin_lo;
    int          num_errors, tests_run, cmd_seen, rst_seen;
    assign scl_w = ~h_scl_oe;
    assign sda_w = ~(h_sda_oe | sda_oe);
    // Straps follow the code: ground, supply, data line, clock line.
    assign pin_hi = sel_hi[1] ? (sel_hi[0] ? scl_w : sda_w) : sel_hi[0];
    assign pin_lo = sel_lo[1] ? (sel_lo[0] ? scl_w : sda_w) : sel_lo[0];
`define CHECK(nm, exp, got) begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
        num_errors++; \
        $display("mismatch %s expected %0h seen %0h", nm, exp, got); \
    end \
end
    adc_i2c_slave_port #(.TIMEOUT_CYCLES(TMO)) uut (
        .clk(clk), .rst(rst), .link_clk(link_clk), .scl_in(scl_w), .sda_in(sda_w),
        .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_pin_lo(pin_lo),
        .addr_select_pin_hi(pin_hi), .conversion_done_n_out(done_out),
        .conversion_done_n_oe(done_oe), .result_valid(result_valid),
        .result_data(result_data), .result_load(result_load), .cont_mode(cont_mode),
        .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .device_reset(device_reset));
    i2c_host_model host (.scl_oe(h_scl_oe), .sda_oe(h_sda_oe), .sda(sda_w));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        link_clk = 1'b0;
        #7;
        forever #16 link_clk = ~link_clk;
    end
    always @(posedge clk) begin
        if (cmd_valid === 1'b1) cmd_seen++;
        if (device_reset === 1'b1) rst_seen++;
    end
    // -------------------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------------------
    task automatic addr_frame(input logic [6:0] a, input logic rw, output logic ack);
        host.start_cond();
        host.send_byte({a, rw}, 1'b0, ack);
    endtask
    task automatic t_write();
        logic ack;
        int   n;
        n = cmd_seen;
        addr_frame(7'h49, 1'b0, ack);
        `CHECK("addr ack", 1'b0, ack)
        host.send_byte(8'h5a, 1'b0, ack);
        `CHECK("data ack", 1'b0, ack)
        host.send_byte(8'ha3, 1'b0, ack);
        host.stop_cond();
        `CHECK("cmd count", n + 2, cmd_seen)
        `CHECK("cmd byte", 8'ha3, cmd_byte)
        $display("write done");
    endtask
    task automatic t_strap();
        logic ack;
        addr_frame(7'h4c, 1'b0, ack);
        `CHECK("foreign nack", 1'b1, ack)
        host.stop_cond();
        @(posedge clk);
        sel_hi <= 2'b11;
        sel_lo <= 2'b00;
        addr_frame(7'h4c, 1'b0, ack);
        `CHECK("new strap ack", 1'b0, ack)
        host.stop_cond();
        $display("strap done");
    endtask
    task automatic t_gencall();
        logic ack;
        int   n;
        n = rst_seen;
        addr_frame(7'h00, 1'b1, ack);
        `CHECK("gc read nack", 1'b1, ack)
        host.stop_cond();
        addr_frame(7'h00, 1'b0, ack);
        `CHECK("gc ack", 1'b0, ack)
        host.send_byte(`GEN_CALL_RESET, 1'b0, ack);
        host.stop_cond();
        `CHECK("gc reset", n + 1, rst_seen)
        $display("general call done");
    endtask
    task automatic t_read();
        logic       ack;
        logic [7:0] b0, b1, b2, b3;
        @(posedge clk);
        result_valid <= 1'b1;
        result_data <= 24'h800001;
        @(posedge clk);
        result_valid <= 1'b0;
        @(posedge clk);
        #1 `CHECK("ready set", 1'b1, done_oe)
        result_load <= 1'b1;
        @(posedge clk);
        result_load <= 1'b0;
        #1 `CHECK("ready clear", 1'b0, done_oe)
        addr_frame(7'h4c, 1'b1, ack);
        `CHECK("read ack", 1'b0, ack)
        host.recv_byte(1'b0, b0);
        host.recv_byte(1'b0, b1);
        host.recv_byte(1'b0, b2);
        host.recv_byte(1'b1, b3);
        host.stop_cond();
        `CHECK("read word", 24'h800001, {b0, b1, b2})
        `CHECK("read pad", 8'h00, b3)
        $display("read done");
    endtask
    task automatic t_cont();
        @(posedge clk);
        cont_mode <= 1'b1;
        result_valid <= 1'b1;
        @(posedge clk);
        @(posedge clk);
        result_valid <= 1'b0;
        for (int i = 0; i < `RELEASE_CYCLES; i++) begin
            #1 `CHECK("release low", 1'b0, done_oe)
            @(posedge clk);
        end
        #1 `CHECK("release end", 1'b1, done_oe)
        result_load <= 1'b1;
        @(posedge clk);
        result_load <= 1'b0;
        cont_mode <= 1'b0;
        $display("continuous done");
    endtask
    task automatic t_timeout();
        logic ack;
        host.start_cond();
        host.send_byte({7'h4c, 1'b0}, 1'b1, ack);
        #300 `CHECK("stall ack", 1'b1, sda_oe)
        repeat (TMO + 20) @(posedge clk);
        #1 `CHECK("timeout release", 1'b0, sda_oe)
        addr_frame(7'h4c, 1'b0, ack);
        `CHECK("restart ack", 1'b0, ack)
        host.stop_cond();
        $display("timeout done");
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        {rst, result_valid, result_load, cont_mode} = 4'h8;
        result_data = 24'h000000;
        sel_hi = 2'b10;
        sel_lo = 2'b01;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (10) @(posedge clk);
        t_write();
        t_strap();
        t_gencall();
        t_read();
        t_cont();
        t_timeout();
        complete_run();
    end
    initial begin
        #2000000;
        num_errors++;
        complete_run();
    end
endmodule
